// file: psrc_consts.svh
// Constants for the parameter store and restore command interpreter
`ifndef PSRC_CONSTS_SVH
`define PSRC_CONSTS_SVH
`define PSRC_INS_STORE_AXIS 8'h07
`define PSRC_INS_RESTORE_AXIS 8'h08
`define PSRC_INS_SET_GLOB 8'h09
`define PSRC_INS_GET_GLOB 8'h0A
`define PSRC_INS_STORE_UVAR 8'h0B
`define PSRC_INS_RESTORE_UVAR 8'h0C
`define PSRC_AXIS_MOTOR 8'h00
`define PSRC_BANK_GLOB 8'h00
`define PSRC_BANK_UVAR 8'h02
`define PSRC_BANK_IRQ 8'h03
`define PSRC_RG_AXIS 2'h0
`define PSRC_RG_GLOB 2'h1
`define PSRC_RG_UVAR 2'h2
`define PSRC_RG_IRQ 2'h3
`define PSRC_ST_OK 8'h64
`define PSRC_ST_ERR 8'hFE
`define PSRC_HOST_ADDR 8'h02
`define PSRC_TARGET_ADDR 8'h01
`define PSRC_POS_ADDR 3'h0
`define PSRC_POS_INS 3'h1
`define PSRC_POS_TYPE 3'h2
`define PSRC_POS_BANK 3'h3
`define PSRC_POS_STAT 3'h2
`define PSRC_POS_V3 3'h4
`define PSRC_POS_V2 3'h5
`define PSRC_POS_V1 3'h6
`define PSRC_POS_V0 3'h7
`define PSRC_LAST_BYTE 4'h8
`define PSRC_DONE_BYTE 4'h9
`define PSRC_N_AXIS 16
`define PSRC_N_GLOB 16
`define PSRC_N_UVAR 16
`define PSRC_N_IRQ 16
`endif

// file: psrc_nvm_model.sv
// Non-volatile word memory model answering the interpreter's memory port
`default_nettype none
module psrc_nvm_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Memory port
  input wire psrc_pkg::psrc_nvm_req_t nvm,
  output var psrc_pkg::psrc_nvm_rsp_t nvm_rsp,
  // Answer pacing
  input wire logic slow
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] mem [1024];
  logic [2:0] wait_cnt;
  // ==========
  // Contents
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = {16'hC0DE, 6'h00, i[9:0]};
    end
  end
  // ==========
  // Access
  always @(posedge core_clk) begin
    nvm_rsp.ack <= 1'b0;
    // Data lines toggle outside a read ack so stale words are never mistaken for answers
    nvm_rsp.rdata <= rst ? 32'h5A5A_5A5A : ~nvm_rsp.rdata;
    if (rst || !nvm.req || nvm_rsp.ack) begin
      wait_cnt <= 3'h0;
    end else if (wait_cnt < (slow ? 3'h6 : 3'h0)) begin
      wait_cnt <= wait_cnt + 3'h1;
    end else begin
      nvm_rsp.ack <= 1'b1;
      if (nvm.we) begin
        mem[nvm.addr] <= nvm.wdata;
      end else begin
        nvm_rsp.rdata <= mem[nvm.addr];
      end
    end
  end
endmodule
`default_nettype wire

// file: psrc_pkg.sv
// Types shared by the parameter store and restore command interpreter
`default_nettype none
package psrc_pkg;
  typedef enum logic [1:0] {S_BOOT, S_RX, S_WAIT, S_TX} psrc_state_t;
  typedef struct packed {
    logic req;
    logic we;
    logic [9:0] addr;
    logic [31:0] wdata;
  } psrc_nvm_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } psrc_nvm_rsp_t;
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } psrc_byte_t;
endpackage
`default_nettype wire

// file: psrc_top.sv
// Command interpreter that stores, restores, sets and reads persistent parameters
`include "psrc_consts.svh"
`default_nettype none
module psrc_top #(
  parameter int N_AXIS = `PSRC_N_AXIS,
  parameter int N_GLOB = `PSRC_N_GLOB,
  parameter int N_UVAR = `PSRC_N_UVAR,
  parameter int N_IRQ = `PSRC_N_IRQ,
  parameter logic [7:0] HOST_ADDR = `PSRC_HOST_ADDR,
  parameter logic [7:0] TARGET_ADDR = `PSRC_TARGET_ADDR,
  parameter logic [7:0] ERR_STATUS = `PSRC_ST_ERR
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Command byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  output var logic rx_ready,
  // Reply byte stream
  output var psrc_pkg::psrc_byte_t tx,
  input wire logic tx_ready,
  // Non-volatile memory port
  output var psrc_pkg::psrc_nvm_req_t nvm,
  input wire psrc_pkg::psrc_nvm_rsp_t nvm_rsp,
  // Status
  output var logic [31:0] accum,
  output var logic restore_busy
);

  typedef struct packed {
    psrc_pkg::psrc_state_t st;
    logic [3:0] cnt;
    logic [7:0] sum;
    logic [7:0][7:0] rbuf;
    logic [7:0][7:0] rply;
    logic [N_AXIS-1:0][31:0] axis;
    logic [N_GLOB-1:0][31:0] glob;
    logic [N_UVAR-1:0][31:0] uvar;
    logic [N_IRQ-1:0][31:0] irq;
    logic [31:0] accum;
    psrc_pkg::psrc_nvm_req_t nvm;
    psrc_pkg::psrc_byte_t tx;
    logic rx_ready;
    logic boot;
    logic [1:0] op_rg;
    logic [7:0] op_ix;
  } psrc_regs_t;

  psrc_regs_t s;
  psrc_regs_t next_s;

  // ==========================================================
  // Frame field views
  logic [7:0] f_ins;
  logic [7:0] f_typ;
  logic [7:0] f_bnk;
  logic [31:0] f_val;
  logic frame_end;
  logic frame_ok;
  logic [31:0] sel_val;

  assign f_ins = s.rbuf[`PSRC_POS_INS];
  assign f_typ = s.rbuf[`PSRC_POS_TYPE];
  assign f_bnk = s.rbuf[`PSRC_POS_BANK];
  assign f_val = {s.rbuf[`PSRC_POS_V3], s.rbuf[`PSRC_POS_V2],
                  s.rbuf[`PSRC_POS_V1], s.rbuf[`PSRC_POS_V0]};
  assign frame_end = (s.st == psrc_pkg::S_RX) && rx_valid && (s.cnt == `PSRC_LAST_BYTE);
  assign frame_ok = frame_end && (rx_byte == s.sum) && (s.rbuf[`PSRC_POS_ADDR] == TARGET_ADDR);

  // ==========================================================
  // Decoding helpers
  function automatic logic [8:0] lim(input logic [1:0] rg);
    case (rg)
      `PSRC_RG_AXIS: lim = 9'(N_AXIS);
      `PSRC_RG_GLOB: lim = 9'(N_GLOB);
      `PSRC_RG_UVAR: lim = 9'(N_UVAR);
      default: lim = 9'(N_IRQ);
    endcase
  endfunction

  function automatic logic [1:0] bank_rg(input logic [7:0] bnk);
    if (bnk == `PSRC_BANK_GLOB) begin
      bank_rg = `PSRC_RG_GLOB;
    end else if (bnk == `PSRC_BANK_UVAR) begin
      bank_rg = `PSRC_RG_UVAR;
    end else begin
      bank_rg = `PSRC_RG_IRQ;
    end
  endfunction

  function automatic logic bank_ok(input logic [7:0] bnk, input logic [7:0] typ);
    bank_ok = ((bnk == `PSRC_BANK_GLOB) || (bnk == `PSRC_BANK_UVAR) ||
               (bnk == `PSRC_BANK_IRQ)) && ({1'b0, typ} < lim(bank_rg(bnk)));
  endfunction

  function automatic logic [31:0] get_val(input logic [1:0] rg, input logic [7:0] ix);
    case (rg)
      `PSRC_RG_AXIS: get_val = s.axis[int'(ix)];
      `PSRC_RG_GLOB: get_val = s.glob[int'(ix)];
      `PSRC_RG_UVAR: get_val = s.uvar[int'(ix)];
      default: get_val = s.irq[int'(ix)];
    endcase
  endfunction

  function automatic psrc_pkg::psrc_nvm_req_t nvm_cmd(input logic we, input logic [1:0] rg,
                                                      input logic [7:0] ix,
                                                      input logic [31:0] wd);
    nvm_cmd.req = 1'b1;
    nvm_cmd.we = we;
    nvm_cmd.addr = {rg, ix};
    nvm_cmd.wdata = wd;
  endfunction


  // ==========================================================
  // Next state
  always_comb begin
    logic wr_en;
    logic [1:0] wr_rg;
    logic [7:0] wr_ix;
    logic [31:0] wr_val;
    logic start_tx;
    logic err;
    logic [8:0] nix;
    wr_en = 1'b0;
    wr_rg = `PSRC_RG_AXIS;
    wr_ix = 8'h00;
    wr_val = 32'h0000_0000;
    start_tx = 1'b0;
    err = 1'b0;
    nix = {1'b0, s.op_ix} + 9'h001;
    // Read here, not in an assign, so a changed stored word re-evaluates it
    sel_val = get_val(bank_rg(f_bnk), f_typ);
    next_s = s;
    case (s.st)
      psrc_pkg::S_BOOT: begin
        // Power-up walk reads every stored axis, user variable and global word back before commands are taken; bank 3 words are not read
        next_s.nvm = nvm_cmd(1'b0, s.op_rg, s.op_ix, 32'h0000_0000);
        next_s.st = psrc_pkg::S_WAIT;
      end
      psrc_pkg::S_RX: begin
        if (rx_valid) begin
          if (s.cnt != `PSRC_LAST_BYTE) begin
            next_s.rbuf[s.cnt[2:0]] = rx_byte;
            next_s.sum = s.sum + rx_byte;
            next_s.cnt = s.cnt + 4'h1;
          end else begin
            next_s.cnt = 4'h0;
            next_s.sum = 8'h00;
            // Frames for other targets or with a bad checksum vanish silently
            if (frame_ok) begin
              next_s.rply = '0;
              next_s.rply[`PSRC_POS_ADDR] = HOST_ADDR;
              next_s.rply[`PSRC_POS_INS] = TARGET_ADDR;
              next_s.rply[`PSRC_POS_STAT] = `PSRC_ST_OK;
              next_s.rply[`PSRC_POS_BANK] = f_ins;
              next_s.op_ix = f_typ;
              case (f_ins)
                `PSRC_INS_STORE_AXIS, `PSRC_INS_RESTORE_AXIS: begin
                  if ((f_bnk == `PSRC_AXIS_MOTOR) && ({1'b0, f_typ} < lim(`PSRC_RG_AXIS))) begin
                    next_s.nvm = nvm_cmd(f_ins == `PSRC_INS_STORE_AXIS, `PSRC_RG_AXIS, f_typ,
                                         get_val(`PSRC_RG_AXIS, f_typ));
                    next_s.op_rg = `PSRC_RG_AXIS;
                    next_s.st = psrc_pkg::S_WAIT;
                  end else begin
                    err = 1'b1;
                  end
                end
                `PSRC_INS_STORE_UVAR, `PSRC_INS_RESTORE_UVAR: begin
                  if ((f_bnk == `PSRC_BANK_UVAR) && ({1'b0, f_typ} < lim(`PSRC_RG_UVAR))) begin
                    next_s.nvm = nvm_cmd(f_ins == `PSRC_INS_STORE_UVAR, `PSRC_RG_UVAR, f_typ,
                                         get_val(`PSRC_RG_UVAR, f_typ));
                    next_s.op_rg = `PSRC_RG_UVAR;
                    next_s.st = psrc_pkg::S_WAIT;
                  end else begin
                    err = 1'b1;
                  end
                end
                `PSRC_INS_SET_GLOB: begin
                  if (bank_ok(f_bnk, f_typ)) begin
                    wr_en = 1'b1;
                    wr_rg = bank_rg(f_bnk);
                    wr_ix = f_typ;
                    wr_val = f_val;
                    if (f_bnk == `PSRC_BANK_GLOB) begin
                      // Reply waits for the commit so an ack means it is durable
                      next_s.nvm = nvm_cmd(1'b1, `PSRC_RG_GLOB, f_typ, f_val);
                      next_s.op_rg = `PSRC_RG_GLOB;
                      next_s.st = psrc_pkg::S_WAIT;
                    end else begin
                      start_tx = 1'b1;
                    end
                  end else begin
                    err = 1'b1;
                  end
                end
                `PSRC_INS_GET_GLOB: begin
                  if (bank_ok(f_bnk, f_typ)) begin
                    next_s.accum = sel_val;
                    next_s.rply[`PSRC_POS_V3] = sel_val[31:24];
                    next_s.rply[`PSRC_POS_V2] = sel_val[23:16];
                    next_s.rply[`PSRC_POS_V1] = sel_val[15:8];
                    next_s.rply[`PSRC_POS_V0] = sel_val[7:0];
                    start_tx = 1'b1;
                  end else begin
                    err = 1'b1;
                  end
                end
                default: begin
                end
              endcase
              if (err) begin
                next_s.rply[`PSRC_POS_STAT] = ERR_STATUS;
                start_tx = 1'b1;
              end
            end
          end
        end
      end
      psrc_pkg::S_WAIT: begin
        if (nvm_rsp.ack) begin
          next_s.nvm.req = 1'b0;
          if (!s.nvm.we) begin
            wr_en = 1'b1;
            wr_rg = s.op_rg;
            wr_ix = s.op_ix;
            wr_val = nvm_rsp.rdata;
          end
          if (s.boot) begin
            next_s.st = psrc_pkg::S_BOOT;
            if (nix == lim(s.op_rg)) begin
              next_s.op_ix = 8'h00;
              // Order of the walk: axis, then user variables, then module settings
              case (s.op_rg)
                `PSRC_RG_AXIS: next_s.op_rg = `PSRC_RG_UVAR;
                `PSRC_RG_UVAR: next_s.op_rg = `PSRC_RG_GLOB;
                default: begin
                  next_s.boot = 1'b0;
                  next_s.st = psrc_pkg::S_RX;
                end
              endcase
            end else begin
              next_s.op_ix = nix[7:0];
            end
          end else begin
            start_tx = 1'b1;
          end
        end
      end
      default: begin
        if (tx_ready) begin
          if (s.cnt < `PSRC_LAST_BYTE) begin
            next_s.tx.data = s.rply[s.cnt[2:0]];
            next_s.sum = s.sum + s.rply[s.cnt[2:0]];
            next_s.cnt = s.cnt + 4'h1;
          end else if (s.cnt == `PSRC_LAST_BYTE) begin
            next_s.tx.data = s.sum;
            next_s.cnt = `PSRC_DONE_BYTE;
          end else begin
            next_s.tx.valid = 1'b0;
            next_s.cnt = 4'h0;
            next_s.sum = 8'h00;
            next_s.st = psrc_pkg::S_RX;
          end
        end
      end
    endcase
    if (wr_en) begin
      case (wr_rg)
        `PSRC_RG_AXIS: next_s.axis[int'(wr_ix)] = wr_val;
        `PSRC_RG_GLOB: next_s.glob[int'(wr_ix)] = wr_val;
        `PSRC_RG_UVAR: next_s.uvar[int'(wr_ix)] = wr_val;
        default: next_s.irq[int'(wr_ix)] = wr_val;
      endcase
    end
    if (start_tx) begin
      next_s.st = psrc_pkg::S_TX;
      next_s.tx.valid = 1'b1;
      next_s.tx.data = next_s.rply[`PSRC_POS_ADDR];
      next_s.sum = next_s.rply[`PSRC_POS_ADDR];
      next_s.cnt = 4'h1;
    end
    next_s.rx_ready = (next_s.st == psrc_pkg::S_RX);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.st <= psrc_pkg::S_BOOT;
      s.boot <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rx_ready = s.rx_ready;
  assign tx = s.tx;
  assign nvm = s.nvm;
  assign accum = s.accum;
  assign restore_busy = s.boot;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  chk_frame_order: assert property (
    (s.st == psrc_pkg::S_RX) && rx_valid && (s.cnt < `PSRC_LAST_BYTE)
    |=> s.rbuf[$past(s.cnt[2:0])] == $past(rx_byte)) else $error("frame byte misplaced");
  chk_store_axis: assert property (
    frame_ok && (f_ins == `PSRC_INS_STORE_AXIS) && (f_bnk == `PSRC_AXIS_MOTOR) &&
    ({1'b0, f_typ} < lim(`PSRC_RG_AXIS))
    |=> nvm.req && nvm.we && (nvm.addr == {`PSRC_RG_AXIS, $past(f_typ)}))
    else $error("axis store not issued");
  chk_restore_axis: assert property (
    frame_ok && (f_ins == `PSRC_INS_RESTORE_AXIS) && (f_bnk == `PSRC_AXIS_MOTOR) &&
    ({1'b0, f_typ} < lim(`PSRC_RG_AXIS))
    |=> nvm.req && !nvm.we && (nvm.addr == {`PSRC_RG_AXIS, $past(f_typ)}))
    else $error("axis restore not issued");
  chk_boot_axis: assert property (
    $fell(rst) |=> nvm.req && !nvm.we && (nvm.addr == {`PSRC_RG_AXIS, 8'h00}) && restore_busy)
    else $error("boot restore did not start");
  chk_set_uvar: assert property (
    frame_ok && (f_ins == `PSRC_INS_SET_GLOB) && (f_bnk == `PSRC_BANK_UVAR) && bank_ok(f_bnk, f_typ)
    |=> s.uvar[$past(f_typ)] == $past(f_val)) else $error("user variable not set");
  chk_set_irq: assert property (
    frame_ok && (f_ins == `PSRC_INS_SET_GLOB) && (f_bnk == `PSRC_BANK_IRQ) && bank_ok(f_bnk, f_typ)
    |=> s.irq[$past(f_typ)] == $past(f_val)) else $error("bank 3 word not set");
  chk_auto_commit: assert property (
    frame_ok && (f_ins == `PSRC_INS_SET_GLOB) && (f_bnk == `PSRC_BANK_GLOB) && bank_ok(f_bnk, f_typ)
    |=> nvm.req && nvm.we && (nvm.addr == {`PSRC_RG_GLOB, $past(f_typ)}) &&
        (nvm.wdata == $past(f_val)) && (s.glob[$past(f_typ)] == $past(f_val)))
    else $error("bank 0 write not committed");
  chk_get_accum: assert property (
    frame_ok && (f_ins == `PSRC_INS_GET_GLOB) && bank_ok(f_bnk, f_typ)
    |=> (accum == $past(sel_val)) && tx.valid && (s.rply[`PSRC_POS_V0] == $past(sel_val[7:0])))
    else $error("read value not in accumulator");
  chk_store_uvar: assert property (
    frame_ok && (f_ins == `PSRC_INS_STORE_UVAR) && (f_bnk == `PSRC_BANK_UVAR) &&
    ({1'b0, f_typ} < lim(`PSRC_RG_UVAR))
    |=> nvm.req && nvm.we && (nvm.wdata == s.uvar[$past(f_typ)])) else $error("uvar store missing");
  chk_restore_uvar: assert property (
    (s.st == psrc_pkg::S_WAIT) && nvm_rsp.ack && !s.nvm.we && !s.boot &&
    (s.op_rg == `PSRC_RG_UVAR)
    |=> s.uvar[$past(s.op_ix)] == $past(nvm_rsp.rdata)) else $error("uvar not reloaded");
  chk_boot_uvar: assert property (
    $fell(rst) |-> ##[1:1000] (nvm.req && !nvm.we && (nvm.addr[9:8] == `PSRC_RG_UVAR)))
    else $error("user variables not restored at boot");
  chk_ok_status: assert property (
    (s.st == psrc_pkg::S_WAIT) && nvm_rsp.ack && !s.boot
    |=> tx.valid && (s.rply[`PSRC_POS_STAT] == `PSRC_ST_OK)) else $error("no OK reply");
  chk_reply_head: assert property (
    $rose(tx.valid) |-> (tx.data == HOST_ADDR) && (s.rply[`PSRC_POS_INS] == TARGET_ADDR))
    else $error("reply header wrong");
  chk_bad_sum: assert property (
    frame_end && (rx_byte != s.sum) |=> (s.st == psrc_pkg::S_RX) && !tx.valid && !nvm.req)
    else $error("bad checksum frame acted on");

  cov_boot_done: cover property ($fell(restore_busy));
  cov_set_glob: cover property (frame_ok && (f_ins == `PSRC_INS_SET_GLOB) ##[1:20] !tx.valid);
  cov_get_glob: cover property (frame_ok && (f_ins == `PSRC_INS_GET_GLOB));
  cov_restore: cover property (frame_ok && (f_ins == `PSRC_INS_RESTORE_AXIS));

endmodule
`default_nettype wire

// file: psrc_top_tb.sv
// Self-checking bench for the parameter store and restore command interpreter
`include "psrc_consts.svh"
`default_nettype none
module psrc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk;
  logic rst;
  logic rx_valid;
  logic [7:0] rx_byte;
  logic rx_ready;
  psrc_pkg::psrc_byte_t tx;
  logic tx_ready;
  psrc_pkg::psrc_nvm_req_t nvm;
  psrc_pkg::psrc_nvm_rsp_t nvm_rsp;
  logic [31:0] accum;
  logic restore_busy;
  logic slow;
  logic stall;
  int error_cnt;
  int compares;
  int rd_cnt [4];
  logic [7:0] rep [9];

  psrc_top u_dut (.core_clk(core_clk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .nvm(nvm), .nvm_rsp(nvm_rsp),
    .accum(accum), .restore_busy(restore_busy));
  psrc_nvm_model u_nvm (.core_clk(core_clk), .rst(rst), .nvm(nvm), .nvm_rsp(nvm_rsp),
    .slow(slow));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Reads per memory region while the power-up restore runs
  always @(posedge core_clk) begin
    if (rst) begin
      rd_cnt = '{0, 0, 0, 0};
    end else if (restore_busy && nvm.req && nvm_rsp.ack && !nvm.we) begin
      rd_cnt[nvm.addr[9:8]]++;
    end
  end

  // ==========
  // Reporting
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hang(input string what);
    error_cnt++;
    $display("unexpected %s: expected completion seen timeout", what);
    finish_test();
  endtask

  function automatic logic [31:0] pre(input logic [9:0] a);
    return {16'hC0DE, 6'h00, a};
  endfunction

  // ==========
  // Frame traffic
  task automatic put_byte(input logic [7:0] b);
    int n;
    n = 0;
    rx_valid <= 1'b1;
    rx_byte <= b;
    do begin
      @(posedge core_clk);
      n++;
    end while (rx_ready !== 1'b1 && n < 100);
    if (n >= 100) hang("rx_ready");
  endtask

  task automatic send(input logic [7:0] adr, ins, typ, bank, input logic [31:0] val,
                      input logic [7:0] skew);
    logic [7:0] f [9];
    f = '{adr, ins, typ, bank, val[31:24], val[23:16], val[15:8], val[7:0], skew};
    for (int i = 0; i < 8; i++) f[8] += f[i];
    for (int i = 0; i < 9; i++) put_byte(f[i]);
    rx_valid <= 1'b0;
  endtask

  task automatic get_reply();
    int k;
    int n;
    k = 0;
    n = 0;
    while (k < 9 && n < 300) begin
      // Stalling halves the accept rate to prove the reply holds its byte
      tx_ready <= stall ? ~tx_ready : 1'b1;
      @(posedge core_clk);
      n++;
      if (tx.valid === 1'b1 && tx_ready === 1'b1) begin
        rep[k] = tx.data;
        k++;
      end
    end
    tx_ready <= 1'b0;
    if (k < 9) hang("reply");
  endtask

  task automatic xact(input logic [7:0] ins, typ, bank, input logic [31:0] val,
                      input logic [7:0] st, input logic [31:0] exp);
    logic [7:0] sum;
    send(`PSRC_TARGET_ADDR, ins, typ, bank, val, 8'h00);
    get_reply();
    cmp8("reply host", `PSRC_HOST_ADDR, rep[0]);
    cmp8("reply target", `PSRC_TARGET_ADDR, rep[1]);
    cmp8("reply status", st, rep[2]);
    cmp8("reply instruction", ins, rep[3]);
    cmp32("reply value", exp, {rep[4], rep[5], rep[6], rep[7]});
    sum = 8'h00;
    for (int i = 0; i < 8; i++) sum += rep[i];
    cmp8("reply checksum", sum, rep[8]);
  endtask

  task automatic quiet(input string what);
    int seen;
    seen = 0;
    repeat (20) begin
      @(posedge core_clk);
      if (tx.valid !== 1'b0) seen++;
    end
    cmp32({what, " replies"}, 32'h0, seen);
    cmp32({what, " ready"}, 32'h1, {31'h0, rx_ready});
  endtask

  // ==========
  // Scenarios
  task automatic t_boot();
    int n;
    n = 0;
    while (restore_busy !== 1'b0 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) hang("restore_busy");
    cmp32("axis boot reads", 32'h10, rd_cnt[0]);
    cmp32("user var boot reads", 32'h10, rd_cnt[2]);
    xact(`PSRC_INS_GET_GLOB, 8'h03, `PSRC_BANK_UVAR, 32'hFFFF_FFFF, `PSRC_ST_OK,
         pre(10'h203));
    cmp32("accum", pre(10'h203), accum);
    $display("test boot done");
  endtask

  task automatic t_banks();
    logic [7:0] bk [3];
    bk = '{`PSRC_BANK_GLOB, `PSRC_BANK_UVAR, `PSRC_BANK_IRQ};
    for (int i = 0; i < 3; i++) begin
      xact(`PSRC_INS_SET_GLOB, 8'h05, bk[i], {24'hA1B2C3, bk[i]}, `PSRC_ST_OK, 32'h0);
    end
    cmp32("bank0 commit", 32'hA1B2_C300, u_nvm.mem[10'h105]);
    for (int i = 0; i < 3; i++) begin
      xact(`PSRC_INS_GET_GLOB, 8'h05, bk[i], 32'h0, `PSRC_ST_OK, {24'hA1B2C3, bk[i]});
    end
    $display("test banks done");
  endtask

  task automatic t_uvar();
    stall <= 1'b1;
    xact(`PSRC_INS_SET_GLOB, 8'h07, `PSRC_BANK_UVAR, 32'h1357_9BDF, `PSRC_ST_OK, 32'h0);
    xact(`PSRC_INS_STORE_UVAR, 8'h07, `PSRC_BANK_UVAR, 32'hFFFF_FFFF, `PSRC_ST_OK, 32'h0);
    cmp32("stored user var", 32'h1357_9BDF, u_nvm.mem[10'h207]);
    xact(`PSRC_INS_SET_GLOB, 8'h07, `PSRC_BANK_UVAR, 32'h0246_8ACE, `PSRC_ST_OK, 32'h0);
    xact(`PSRC_INS_RESTORE_UVAR, 8'h07, `PSRC_BANK_UVAR, 32'h0, `PSRC_ST_OK, 32'h0);
    xact(`PSRC_INS_GET_GLOB, 8'h07, `PSRC_BANK_UVAR, 32'h0, `PSRC_ST_OK, 32'h1357_9BDF);
    stall <= 1'b0;
    $display("test user var done");
  endtask

  task automatic t_axis();
    slow <= 1'b1;
    u_nvm.mem[10'h006] = 32'hDEAD_0006;
    xact(`PSRC_INS_STORE_AXIS, 8'h06, `PSRC_AXIS_MOTOR, 32'hFFFF_FFFF, `PSRC_ST_OK, 32'h0);
    cmp32("stored axis param", pre(10'h006), u_nvm.mem[10'h006]);
    u_nvm.mem[10'h006] = 32'h600D_0006;
    xact(`PSRC_INS_RESTORE_AXIS, 8'h06, `PSRC_AXIS_MOTOR, 32'h0, `PSRC_ST_OK, 32'h0);
    u_nvm.mem[10'h006] = 32'h0;
    xact(`PSRC_INS_STORE_AXIS, 8'h06, `PSRC_AXIS_MOTOR, 32'h0, `PSRC_ST_OK, 32'h0);
    cmp32("restored axis param", 32'h600D_0006, u_nvm.mem[10'h006]);
    slow <= 1'b0;
    $display("test axis done");
  endtask

  task automatic t_refuse();
    send(`PSRC_TARGET_ADDR, `PSRC_INS_GET_GLOB, 8'h05, 8'h02, 32'h0, 8'h01);
    quiet("bad checksum");
    send(8'h07, `PSRC_INS_GET_GLOB, 8'h05, 8'h02, 32'h0, 8'h00);
    quiet("other target");
    send(`PSRC_TARGET_ADDR, 8'h0D, 8'h00, 8'h00, 32'h0, 8'h00);
    quiet("unknown instruction");
    xact(`PSRC_INS_SET_GLOB, 8'h05, 8'h01, 32'h1, `PSRC_ST_ERR, 32'h0);
    xact(`PSRC_INS_STORE_AXIS, 8'h06, 8'h01, 32'h0, `PSRC_ST_ERR, 32'h0);
    xact(`PSRC_INS_STORE_UVAR, 8'h07, 8'h00, 32'h0, `PSRC_ST_ERR, 32'h0);
    xact(`PSRC_INS_GET_GLOB, 8'h10, `PSRC_BANK_UVAR, 32'h0, `PSRC_ST_ERR, 32'h0);
    xact(`PSRC_INS_RESTORE_AXIS, 8'h10, `PSRC_AXIS_MOTOR, 32'h0, `PSRC_ST_ERR, 32'h0);
    xact(`PSRC_INS_GET_GLOB, 8'h05, 8'h02, 32'h0, `PSRC_ST_OK, 32'hA1B2_C302);
    $display("test refusals done");
  endtask

  initial begin
    rst = 1'b1;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
    slow = 1'b0;
    stall = 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    t_boot();
    t_banks();
    t_uvar();
    t_axis();
    t_refuse();
    finish_test();
  end
endmodule
`default_nettype wire
